// >>> logic/fps_pkg.sv
// Package for the fan PWM fault supervisor: timing counts, states, carriers.
// Assumes a 10 MHz clock; the supervisor synchronises the comparator levels itself.
`default_nettype none
package fps_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  // Fast PWM rate keeps the 32-cycle windows short in simulation
  localparam int unsigned PWM_HZ = 50_000;
  // Clocks per PWM cycle and ramp width
  localparam int unsigned PWM_CYCLE_CLKS = CLK_HZ / PWM_HZ;
  localparam int unsigned RAMP_W = 8;
  localparam int unsigned DUTY_W = 8;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] STARTUP_CYCLES = 6'h20;
  localparam logic [CNT_W-1:0] MISSING_CYCLES = 6'h20;
  localparam logic [CNT_W-1:0] DIAG_CYCLES = 6'h03;
  // Blanking after drive turn-on, in clocks
  localparam int unsigned BLANK_CLKS = 16;
  localparam int unsigned BLANK_W = 5;

  typedef enum logic [2:0] {
    FPS_OFF = 3'h0,
    FPS_START1 = 3'h1,
    FPS_START2 = 3'h2,
    FPS_RUN = 3'h3,
    FPS_DIAG = 3'h4,
    FPS_RESTART = 3'h5,
    FPS_FAULT = 3'h6
  } fps_state_t;

  // Comparator results of the control level
  typedef struct packed {
    logic above_shutdown;
    logic above_autooff;
    logic above_autooff_hyst;
    logic above_overtemp;
  } fps_levels_t;
endpackage
`default_nettype wire

// >>> logic/fps_ramp.sv
// PWM time base: free-running ramp and end-of-cycle tick.
// Assumes one clock domain and a synchronous reset-released design.
`default_nettype none
module fps_ramp
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Time base
  output logic [fps_pkg::RAMP_W-1:0] o_ramp,
  output logic o_tick
);
  import fps_pkg::*;

  localparam logic [RAMP_W-1:0] RAMP_LAST = RAMP_W'(PWM_CYCLE_CLKS - 1);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ramp <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= (o_ramp == RAMP_LAST);
      o_ramp <= (o_ramp == RAMP_LAST) ? '0 : o_ramp + 1'b1;
    end
  end
endmodule // fps_ramp
`default_nettype wire

// >>> logic/fps_supervisor.sv
// Fan PWM fault supervisor: start-up, normal loop, missing-pulse escalation.
// Assumes comparator levels and the commutation pulse come from pins.
`default_nettype none
module fps_supervisor
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Comparator levels and duty from the control level
  input wire fps_pkg::fps_levels_t i_levels,
  input wire logic [fps_pkg::DUTY_W-1:0] i_duty,
  // Commutation sense pulse
  input wire logic i_sense,
  // Fan drive and active-low alarm
  output logic o_fan_drive_out,
  output logic o_alarm_n,
  output fps_pkg::fps_state_t o_state
);
  import fps_pkg::*;

  typedef struct packed {
    fps_levels_t lv_m;
    fps_levels_t lv;
    logic [DUTY_W-1:0] duty_m;
    logic [DUTY_W-1:0] duty_s;
    logic [2:0] sense_sync;
    fps_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [DUTY_W-1:0] duty;
    logic [BLANK_W-1:0] blank;
    logic pulse_seen;
    logic drive;
    logic alarm_n;
  } fps_regs_t;

  fps_regs_t r;
  fps_regs_t next_r;
  logic [1:0] rst_sync;
  logic nrst_int;
  logic [RAMP_W-1:0] ramp;
  logic tick;

  // Window counter wrap
  function automatic logic expired(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
    expired = (c + 1'b1) >= lim;
  endfunction

  // Ramp position scaled to duty width
  function automatic logic [DUTY_W-1:0] ramp_pos(input logic [RAMP_W-1:0] rp);
    logic [RAMP_W+DUTY_W-1:0] prod;
    prod = (RAMP_W+DUTY_W)'(rp) * (RAMP_W+DUTY_W)'(256);
    ramp_pos = DUTY_W'(prod / (RAMP_W+DUTY_W)'(PWM_CYCLE_CLKS));
  endfunction

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign nrst_int = rst_sync[1];

  fps_ramp u_ramp
  (
    .i_clk(i_clk),
    .i_nrst(nrst_int),
    .o_ramp(ramp),
    .o_tick(tick)
  );

  logic sense_rise;
  logic drive_want;
  logic shutdown;
  logic autooff;
  logic pulse;

  always_comb
  begin
    next_r = r;
    next_r.lv_m = i_levels;
    next_r.lv = r.lv_m;
    next_r.duty_m = i_duty;
    next_r.duty_s = r.duty_m;
    next_r.sense_sync = {r.sense_sync[1:0], i_sense};
    sense_rise = r.sense_sync[1] & ~r.sense_sync[2];
    shutdown = ~r.lv.above_shutdown;
    autooff = ~r.lv.above_autooff;
    drive_want = 1'b0;
    // Blank sense edges right after drive turn-on
    pulse = sense_rise & (r.blank == '0);
    if (r.blank != '0)
      next_r.blank = r.blank - 1'b1;
    if (pulse)
      next_r.pulse_seen = 1'b1;
    if (tick)
      next_r.duty = r.duty_s;
    unique case (r.state)
      FPS_OFF:
      begin
        next_r.cnt = '0;
        next_r.pulse_seen = 1'b0;
        if (!shutdown && r.lv.above_autooff_hyst && tick)
          next_r.state = FPS_START1;
      end
      FPS_START1, FPS_START2, FPS_RESTART:
      begin
        drive_want = 1'b1;
        if (pulse)
        begin
          next_r.state = FPS_RUN;
          next_r.cnt = '0;
          next_r.pulse_seen = 1'b0;
        end
        else if (tick)
        begin
          next_r.cnt = r.cnt + 1'b1;
          if (expired(r.cnt, STARTUP_CYCLES))
          begin
            next_r.cnt = '0;
            next_r.state = (r.state == FPS_START1) ? FPS_START2 : FPS_FAULT;
          end
        end
      end
      FPS_RUN:
      begin
        drive_want = ramp_pos(ramp) < r.duty;
        if (tick)
        begin
          if (r.pulse_seen || pulse)
            next_r.cnt = '0;
          else if (expired(r.cnt, MISSING_CYCLES))
          begin
            next_r.cnt = '0;
            next_r.state = FPS_DIAG;
          end
          else
            next_r.cnt = r.cnt + 1'b1;
          next_r.pulse_seen = 1'b0;
        end
      end
      FPS_DIAG:
      begin
        drive_want = 1'b1;
        if (pulse)
        begin
          next_r.state = FPS_RUN;
          next_r.cnt = '0;
          next_r.pulse_seen = 1'b0;
        end
        else if (tick)
        begin
          next_r.cnt = r.cnt + 1'b1;
          if (expired(r.cnt, DIAG_CYCLES))
          begin
            next_r.cnt = '0;
            next_r.state = FPS_RESTART;
          end
        end
      end
      FPS_FAULT:
      begin
        next_r.cnt = '0;
      end
      default:
        next_r.state = FPS_OFF;
    endcase
    // Shutdown resets state, count and pulse flag; auto-off idles unless in fault
    if (shutdown)
    begin
      next_r.state = FPS_OFF;
      next_r.cnt = '0;
      next_r.pulse_seen = 1'b0;
      drive_want = 1'b0;
    end
    else if (autooff && r.state != FPS_FAULT)
    begin
      next_r.state = FPS_OFF;
      drive_want = 1'b0;
    end
    if (r.state == FPS_FAULT && !shutdown)
      drive_want = 1'b0;
    next_r.drive = drive_want;
    if (drive_want && !r.drive)
      next_r.blank = BLANK_W'(BLANK_CLKS - 1);
    if (r.state == FPS_FAULT && !shutdown)
      next_r.alarm_n = 1'b0;
    else if (shutdown || autooff || r.state == FPS_OFF)
      next_r.alarm_n = 1'b1;
    else
      next_r.alarm_n = ~r.lv.above_overtemp;
  end

  always_ff @(posedge i_clk or negedge nrst_int)
  begin
    if (!nrst_int)
    begin
      r.lv_m <= '0;
      r.lv <= '0;
      r.duty_m <= '0;
      r.duty_s <= '0;
      r.sense_sync <= '0;
      r.state <= FPS_OFF;
      r.cnt <= '0;
      r.duty <= '0;
      r.blank <= '0;
      r.pulse_seen <= 1'b0;
      r.drive <= 1'b0;
      r.alarm_n <= 1'b1;
    end
    else
    begin
      r.lv_m <= next_r.lv_m;
      r.lv <= next_r.lv;
      r.duty_m <= next_r.duty_m;
      r.duty_s <= next_r.duty_s;
      r.sense_sync <= next_r.sense_sync;
      r.state <= next_r.state;
      r.cnt <= next_r.cnt;
      r.duty <= next_r.duty;
      r.blank <= next_r.blank;
      r.pulse_seen <= next_r.pulse_seen;
      r.drive <= next_r.drive;
      r.alarm_n <= next_r.alarm_n;
    end
  end

  assign o_fan_drive_out = r.drive;
  assign o_alarm_n = r.alarm_n;
  assign o_state = r.state;

  a_fault_latch: assert property (@(posedge i_clk) disable iff (!nrst_int)
    r.state == FPS_FAULT && r.lv.above_shutdown |=> r.state == FPS_FAULT)
    else $error("fault latch left without shutdown");
  a_fault_outs: assert property (@(posedge i_clk) disable iff (!nrst_int)
    r.state == FPS_FAULT && r.lv.above_shutdown |=> !o_fan_drive_out && !o_alarm_n)
    else $error("fault outputs wrong");
  a_diag_drive: assert property (@(posedge i_clk) disable iff (!nrst_int)
    r.state == FPS_DIAG && r.lv.above_autooff && r.lv.above_shutdown |=> o_fan_drive_out)
    else $error("drive off in diagnostic window");
  a_start_drive: assert property (@(posedge i_clk) disable iff (!nrst_int)
    r.state == FPS_START1 && r.lv.above_autooff && r.lv.above_shutdown |=> o_fan_drive_out)
    else $error("drive off in start-up");
  a_off_quiet: assert property (@(posedge i_clk) disable iff (!nrst_int)
    !r.lv.above_autooff && r.state != FPS_FAULT |=> !o_fan_drive_out && o_alarm_n)
    else $error("auto-off not quiet");
  a_shdn_reset: assert property (@(posedge i_clk) disable iff (!nrst_int)
    !r.lv.above_shutdown |=> r.state == FPS_OFF && r.cnt == '0)
    else $error("shutdown did not reset");
  a_pulse_run: assert property (@(posedge i_clk) disable iff (!nrst_int)
    pulse && r.lv.above_shutdown && r.lv.above_autooff
      && (r.state == FPS_DIAG || r.state == FPS_RESTART) |=> r.state == FPS_RUN)
    else $error("pulse did not return to loop");
  a_overtemp: assert property (@(posedge i_clk) disable iff (!nrst_int)
    r.state == FPS_RUN && r.lv.above_shutdown && r.lv.above_autooff
      |=> o_alarm_n == !$past(r.lv.above_overtemp))
    else $error("alarm does not follow over-temperature");
  a_diag_len: assert property (@(posedge i_clk) disable iff (!nrst_int)
    r.state == FPS_DIAG |-> r.cnt < DIAG_CYCLES)
    else $error("diagnostic window too long");
  a_blank: assert property (@(posedge i_clk) disable iff (!nrst_int)
    $rose(r.drive) |-> r.blank == BLANK_W'(BLANK_CLKS - 1))
    else $error("blanking not started at drive turn-on");

  c_run: cover property (@(posedge i_clk) r.state == FPS_START1 ##1 r.state == FPS_RUN);
  c_diag: cover property (@(posedge i_clk) r.state == FPS_RUN ##1 r.state == FPS_DIAG);
  c_fault: cover property (@(posedge i_clk) r.state == FPS_RESTART ##1 r.state == FPS_FAULT);
  c_release: cover property (@(posedge i_clk) r.state == FPS_FAULT ##1 r.state == FPS_OFF);
endmodule // fps_supervisor
`default_nettype wire

// >>> verif/fps_fan_model.sv
// Fan and sense network model: one commutation pulse per drive turn-on.
// Assumes the bench sets the spin enable and the pulse delay in clocks.
`default_nettype none
module fps_fan_model
(
  // Clock
  input wire logic i_clk,
  // Fan side
  input wire logic i_fan_drive_out,
  input wire logic i_spin,
  input wire logic [7:0] i_gap,
  output logic o_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] since_on = 8'hFF;
  logic drive_q = 1'b0;

  always @(posedge i_clk)
  begin
    drive_q <= i_fan_drive_out;
    if (i_fan_drive_out && !drive_q)
      since_on <= 8'h00;
    else if (since_on != 8'hFF)
      since_on <= since_on + 8'h01;
  end

  // Current only flows while energised; a stalled fan gives no pulse
  assign o_sense = i_spin && i_fan_drive_out && since_on >= i_gap && since_on < i_gap + 8'h04;
endmodule // fps_fan_model
`default_nettype wire

// >>> verif/fan_pwm_fault_supervisor_bench.sv
// Bench for the fan PWM fault supervisor with a fan model on the drive pin.
// Assumes package timing: one PWM cycle is PWM_CYCLE_CLKS clocks.
`default_nettype none
module fan_pwm_fault_supervisor_bench import fps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = PWM_CYCLE_CLKS;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  fps_levels_t levels = '0;
  logic [DUTY_W-1:0] duty = '0;
  logic spin = 1'b1;
  logic [7:0] gap = 8'h05;
  logic sense;
  logic drive;
  logic alarm_n;
  fps_state_t state;
  int n_mismatch = 0;
  int compares = 0;

  initial
  begin
    forever #50 i_clk = ~i_clk;
  end

  fps_supervisor uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_levels(levels), .i_duty(duty),
    .i_sense(sense), .o_fan_drive_out(drive), .o_alarm_n(alarm_n), .o_state(state));
  fps_fan_model fan (.i_clk(i_clk), .i_fan_drive_out(drive), .i_spin(spin), .i_gap(gap),
    .o_sense(sense));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic clocks(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic drive_in(input logic [3:0] l, input logic [DUTY_W-1:0] d);
    @(posedge i_clk);
    levels <= fps_levels_t'(l);
    duty <= d;
    #1;
  endtask

  task automatic wait_state(input fps_state_t s, input int lim);
    int n = 0;
    while (state !== s && n < lim)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask

  task automatic count_high(output int hi);
    hi = 0;
    repeat (CYC)
    begin
      @(posedge i_clk);
      #1;
      if (drive === 1'b1)
        hi++;
    end
  endtask

  task automatic t_reset;
    check(state, FPS_OFF);
    check(drive, 1'b0);
    check(alarm_n, 1'b1);
    @(posedge i_clk);
    i_nrst <= 1'b1;
    $display("reset done");
  endtask

  task automatic t_power_up;
    drive_in(4'hE, 8'h80);
    wait_state(FPS_START1, CYC + 100);
    check(state, FPS_START1);
    clocks(1);
    check(drive, 1'b1);
    // Early pulse falls inside blanking
    clocks(20);
    check(state, FPS_START1);
    @(posedge i_clk);
    gap <= 8'h28;
    wait_state(FPS_RUN, 60);
    check(state, FPS_RUN);
    $display("power_up done");
  endtask

  task automatic t_duty;
    int hi;
    drive_in(4'hE, 8'h00);
    clocks(CYC);
    count_high(hi);
    check(hi != 0, 1'b0);
    check(state, FPS_RUN);
    drive_in(4'hE, 8'h80);
    clocks(CYC);
    count_high(hi);
    check(hi > CYC * 2 / 5 && hi < CYC * 3 / 5, 1'b1);
    check(state, FPS_RUN);
    $display("duty done");
  endtask

  task automatic t_overtemp;
    drive_in(4'hF, 8'h80);
    clocks(5);
    check(alarm_n, 1'b0);
    check(state, FPS_RUN);
    drive_in(4'hE, 8'h80);
    clocks(5);
    check(alarm_n, 1'b1);
    $display("overtemp done");
  endtask

  task automatic t_autooff;
    drive_in(4'h9, 8'h80);
    clocks(5);
    check(state, FPS_OFF);
    check(drive, 1'b0);
    check(alarm_n, 1'b1);
    drive_in(4'hC, 8'h80);
    clocks(CYC + 10);
    check(state, FPS_OFF);
    drive_in(4'hE, 8'h80);
    wait_state(FPS_START1, CYC + 100);
    check(state, FPS_START1);
    wait_state(FPS_RUN, 60);
    check(state, FPS_RUN);
    $display("autooff done");
  endtask

  task automatic t_shutdown;
    drive_in(4'h0, 8'h80);
    clocks(5);
    check(state, FPS_OFF);
    check(drive, 1'b0);
    check(alarm_n, 1'b1);
    drive_in(4'hE, 8'h80);
    wait_state(FPS_START1, CYC + 100);
    check(state, FPS_START1);
    $display("shutdown done");
  endtask

  task automatic t_fault;
    wait_state(FPS_RUN, 60);
    check(state, FPS_RUN);
    @(posedge i_clk);
    spin <= 1'b0;
    wait_state(FPS_DIAG, 34 * CYC);
    check(state, FPS_DIAG);
    clocks(1);
    check(drive, 1'b1);
    wait_state(FPS_RESTART, 4 * CYC);
    check(state, FPS_RESTART);
    wait_state(FPS_FAULT, 34 * CYC);
    check(state, FPS_FAULT);
    clocks(CYC);
    check(state, FPS_FAULT);
    check(drive, 1'b0);
    check(alarm_n, 1'b0);
    drive_in(4'h0, 8'h80);
    clocks(5);
    check(state, FPS_OFF);
    check(alarm_n, 1'b1);
    drive_in(4'hE, 8'h80);
    wait_state(FPS_START1, CYC + 100);
    check(state, FPS_START1);
    wait_state(FPS_START2, 34 * CYC);
    check(state, FPS_START2);
    wait_state(FPS_FAULT, 34 * CYC);
    check(state, FPS_FAULT);
    @(posedge i_clk);
    spin <= 1'b1;
    drive_in(4'h0, 8'h80);
    clocks(5);
    drive_in(4'hE, 8'h80);
    wait_state(FPS_START1, CYC + 100);
    wait_state(FPS_RUN, 60);
    check(state, FPS_RUN);
    $display("fault done");
  endtask

  task automatic complete_run;
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clocks(9);
    t_reset;
    t_power_up;
    t_duty;
    t_overtemp;
    t_autooff;
    t_shutdown;
    t_fault;
    complete_run;
  end

  initial
  begin
    repeat (200 * CYC) @(posedge i_clk);
    n_mismatch++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    complete_run;
  end
endmodule // fan_pwm_fault_supervisor_bench
`default_nettype wire
